// File: src/sbgp_params.svh
// Purpose: constants of the seven-pin port with alternate functions
// Assumes: 32-bit register words, byte offsets within the port block
// Notes:   all reset values are zero
//
// What this block does
// [RULE_01] seven pins, each bit separately input or output
// [RULE_02] reset: port mode, input, driver, pull-up off
// [RULE_03] both select bits zero gives plain port
// [RULE_04] software never sets both select bits
// [RULE_05] block at fixed base, seven fixed offsets
// [RULE_06] pin_value bits 6-0 read/write, rest zero
// [RULE_07] drive_enable bit one turns driver on
// [RULE_08] select one routes serial and remote functions
// [RULE_09] select two routes clear-to-send, pins 6, 2
// [RULE_10] open_drain_select one gives open-drain output
// [RULE_11] pullup_enable one turns pull-up on
// [RULE_12] input_buffer_enable one opens input buffer
// [RULE_13] pin_value reads pin if input enabled, else latch
`ifndef SBGP_PARAMS_SVH
`define SBGP_PARAMS_SVH

`define SBGP_NPINS      7
`define SBGP_ADDR_W     6
`define SBGP_BASE       32'h4000_0100
`define SBGP_OFF_DATA   6'h00
`define SBGP_OFF_DRIVE  6'h04
`define SBGP_OFF_FSEL1  6'h08
`define SBGP_OFF_FSEL2  6'h0c
`define SBGP_OFF_ODRN   6'h28
`define SBGP_OFF_PULL   6'h2c
`define SBGP_OFF_INEN   6'h38
`define SBGP_RST_BITS   7'h00
`define SBGP_RST_WORD   32'h0000_0000
`define SBGP_FSEL2_MASK 7'h44
`define SBGP_B_TX0      0
`define SBGP_B_RX0      1
`define SBGP_B_SCK0     2
`define SBGP_B_RC       3
`define SBGP_B_TX1      4
`define SBGP_B_RX1      5
`define SBGP_B_SCK1     6

`endif

// File: src/sbgp_pkg.sv
// Purpose: types of the seven-pin port
// Assumes: constants come from sbgp_params.svh
// Notes:   the whole block state is one packed struct
`include "sbgp_params.svh"

package sbgp_pkg;

    typedef logic [`SBGP_NPINS-1:0] sbgp_pins_t;

    typedef struct packed {
        sbgp_pins_t  data;
        sbgp_pins_t  drive;
        sbgp_pins_t  fsel1;
        sbgp_pins_t  fsel2;
        sbgp_pins_t  odrn;
        sbgp_pins_t  pull;
        sbgp_pins_t  inen;
        sbgp_pins_t  sync1;
        sbgp_pins_t  sync2;
        sbgp_pins_t  sync3;
        sbgp_pins_t  level;
        sbgp_pins_t  pout;
        sbgp_pins_t  poe;
        sbgp_pins_t  alt_in;
        logic [1:0]  cts;
        logic        ack;
        logic [31:0] rdata;
    } sbgp_state_s;

endpackage

// File: src/sbgp_port.sv
// Purpose: seven-pin port with alternate-function routing
// Assumes: Avalon-MM slave with one wait cycle per access while ce is high
// Notes:   pin outputs and peripheral inputs are registered
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "sbgp_params.svh"

module sbgp_port (
    input  wire logic                     clock,
    input  wire logic                     srst,
    input  wire logic                     ce,
    input  wire logic [`SBGP_ADDR_W-1:0]  address,
    input  wire logic                     read,
    input  wire logic                     write,
    input  wire logic [31:0]              writedata,
    input  wire logic [3:0]               byteenable,
    output logic      [31:0]              readdata,
    output logic                          waitrequest,
    input  wire logic [`SBGP_NPINS-1:0]   port_pins_in,
    output logic      [`SBGP_NPINS-1:0]   port_pins_out,
    output logic      [`SBGP_NPINS-1:0]   port_pins_oe,
    output logic      [`SBGP_NPINS-1:0]   port_pins_pullup,
    output logic      [`SBGP_NPINS-1:0]   port_pins_input_en,
    input  wire logic                     serial0_transmit,
    input  wire logic                     serial0_clock_out,
    input  wire logic                     serial0_clock_oe,
    output logic                          serial0_receive,
    output logic                          serial0_clock_in,
    output logic                          serial0_clear_to_send,
    input  wire logic                     serial1_transmit,
    input  wire logic                     serial1_clock_out,
    input  wire logic                     serial1_clock_oe,
    output logic                          serial1_receive,
    output logic                          serial1_clock_in,
    output logic                          serial1_clear_to_send,
    output logic                          remote_control_input
);

    sbgp_pkg::sbgp_state_s s_q;
    sbgp_pkg::sbgp_state_s s_d;

    logic                   req;
    logic                   accept;
    sbgp_pkg::sbgp_pins_t   alt_val;
    sbgp_pkg::sbgp_pins_t   alt_drv;
    sbgp_pkg::sbgp_pins_t   sel_any;
    sbgp_pkg::sbgp_pins_t   val;
    sbgp_pkg::sbgp_pins_t   drv;
    sbgp_pkg::sbgp_pins_t   rd_pins;
    sbgp_pkg::sbgp_pins_t   wbits;
    logic [31:0]            rd_word;

    assign req    = read | write;
    // the access completes on the second cycle; a frozen block holds it off
    assign accept = req & s_q.ack & ce;

    always_comb begin
        waitrequest = req & ~accept;
    end

    // function-select masks: select two only has pins 6 and 2
    always_comb begin
        wbits   = writedata[`SBGP_NPINS-1:0];
        sel_any = s_q.fsel1 | s_q.fsel2;                                // RULE_03
    end

    // pin_value reads the filtered pin where the buffer is open
    always_comb begin
        rd_pins = (s_q.level & s_q.inen) | (s_q.data & ~s_q.inen);      // RULE_13
    end

    always_comb begin
        rd_word = `SBGP_RST_WORD;                                       // RULE_06
        unique case (address)
            `SBGP_OFF_DATA:  rd_word[`SBGP_NPINS-1:0] = rd_pins;        // RULE_05
            `SBGP_OFF_DRIVE: rd_word[`SBGP_NPINS-1:0] = s_q.drive;
            `SBGP_OFF_FSEL1: rd_word[`SBGP_NPINS-1:0] = s_q.fsel1;
            `SBGP_OFF_FSEL2: rd_word[`SBGP_NPINS-1:0] = s_q.fsel2;
            `SBGP_OFF_ODRN:  rd_word[`SBGP_NPINS-1:0] = s_q.odrn;
            `SBGP_OFF_PULL:  rd_word[`SBGP_NPINS-1:0] = s_q.pull;
            `SBGP_OFF_INEN:  rd_word[`SBGP_NPINS-1:0] = s_q.inen;
            default:         rd_word = `SBGP_RST_WORD;
        endcase
    end

    // what each alternate function wants to drive onto its pin
    always_comb begin
        alt_val = `SBGP_RST_BITS;
        alt_drv = `SBGP_RST_BITS;
        alt_val[`SBGP_B_TX0]  = serial0_transmit;                       // RULE_08
        alt_drv[`SBGP_B_TX0]  = 1'b1;
        alt_val[`SBGP_B_TX1]  = serial1_transmit;
        alt_drv[`SBGP_B_TX1]  = 1'b1;
        // select one wins if software breaks the one-select discipline
        if (s_q.fsel1[`SBGP_B_SCK0]) begin                              // RULE_04
            alt_val[`SBGP_B_SCK0] = serial0_clock_out;
            alt_drv[`SBGP_B_SCK0] = serial0_clock_oe;
        end
        if (s_q.fsel1[`SBGP_B_SCK1]) begin
            alt_val[`SBGP_B_SCK1] = serial1_clock_out;
            alt_drv[`SBGP_B_SCK1] = serial1_clock_oe;
        end
    end

    // per-pin choice between port latch and peripheral
    always_comb begin
        val = (alt_val & sel_any) | (s_q.data & ~sel_any);              // RULE_01
        drv = (alt_drv & sel_any) | (s_q.drive & ~sel_any);             // RULE_07
    end

    always_comb begin
        s_d = s_q;
        if (ce) begin
            s_d.sync1 = port_pins_in;
            s_d.sync2 = s_q.sync1;
            s_d.sync3 = s_q.sync2;
            // a bit changes only once two stages agree
            for (int i = 0; i < `SBGP_NPINS; i++) begin
                if (s_q.sync2[i] == s_q.sync3[i]) begin
                    s_d.level[i] = s_q.sync3[i];
                end
            end
            s_d.ack = req & ~s_q.ack;
            if (req & ~s_q.ack) begin
                s_d.rdata = read ? rd_word : `SBGP_RST_WORD;
            end
            if (write & s_q.ack & byteenable[0]) begin
                unique case (address)
                    `SBGP_OFF_DATA:  s_d.data  = wbits;                 // RULE_06
                    `SBGP_OFF_DRIVE: s_d.drive = wbits;                 // RULE_07
                    `SBGP_OFF_FSEL1: s_d.fsel1 = wbits;                 // RULE_08
                    `SBGP_OFF_FSEL2: s_d.fsel2 = wbits & `SBGP_FSEL2_MASK; // RULE_09
                    `SBGP_OFF_ODRN:  s_d.odrn  = wbits;                 // RULE_10
                    `SBGP_OFF_PULL:  s_d.pull  = wbits;                 // RULE_11
                    `SBGP_OFF_INEN:  s_d.inen  = wbits;                 // RULE_12
                    default:         s_d.rdata = s_q.rdata;
                endcase
            end
            // open-drain only sinks: a one releases the pin
            s_d.pout = val & ~s_q.odrn;                                 // RULE_10
            s_d.poe  = drv & ~(s_q.odrn & val);
            // peripherals see nothing while the input buffer is shut
            s_d.alt_in = s_q.level & s_q.inen & s_q.fsel1;              // RULE_12
            s_d.cts[0] = s_q.level[`SBGP_B_SCK0] & s_q.inen[`SBGP_B_SCK0]
                       & s_q.fsel2[`SBGP_B_SCK0];                       // RULE_09
            s_d.cts[1] = s_q.level[`SBGP_B_SCK1] & s_q.inen[`SBGP_B_SCK1]
                       & s_q.fsel2[`SBGP_B_SCK1];
        end
        // reset acts even with the clock enable low
        if (srst) begin
            s_d = '0;                                                   // RULE_02
        end
    end

    always_ff @(posedge clock) begin
        s_q <= s_d;
    end

    assign readdata              = s_q.rdata;
    assign port_pins_out         = s_q.pout;
    assign port_pins_oe          = s_q.poe;
    assign port_pins_pullup      = s_q.pull;                            // RULE_11
    assign port_pins_input_en    = s_q.inen;
    assign serial0_receive       = s_q.alt_in[`SBGP_B_RX0];
    assign serial0_clock_in      = s_q.alt_in[`SBGP_B_SCK0];
    assign serial0_clear_to_send = s_q.cts[0];
    assign serial1_receive       = s_q.alt_in[`SBGP_B_RX1];
    assign serial1_clock_in      = s_q.alt_in[`SBGP_B_SCK1];
    assign serial1_clear_to_send = s_q.cts[1];
    assign remote_control_input  = s_q.alt_in[`SBGP_B_RC];

    // ---- checks ----
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    logic w_go;
    logic r_go;
    assign w_go = write & accept & byteenable[0];
    assign r_go = read & accept;

    property p_reset_quiet;
        @(posedge clock) disable iff (1'b0)
        srst |=> (port_pins_oe == 7'h00) && (port_pins_pullup == 7'h00)
                 && (port_pins_input_en == 7'h00) && (s_q.fsel1 == 7'h00);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("reset left pin on"); // RULE_02

    property p_one_wait;
        (req && !s_q.ack && ce) ##1 (req && ce) |-> !waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("access not done in 2 cycles"); // RULE_05

    property p_data_write;
        (w_go && address == `SBGP_OFF_DATA) |=> s_q.data == $past(writedata[6:0]);
    endproperty
    a_data_write: assert property (p_data_write) else $error("pin_value write lost"); // RULE_06

    property p_upper_zero;
        readdata[31:7] == 25'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set"); // RULE_06

    property p_read_source;
        (r_go && address == `SBGP_OFF_DATA && $past(ce))
            |-> readdata[6:0] == $past(rd_pins);
    endproperty
    a_read_source: assert property (p_read_source) else $error("pin_value read wrong"); // RULE_13

    property p_fsel2_mask;
        (s_q.fsel2 & ~`SBGP_FSEL2_MASK) == 7'h00;
    endproperty
    a_fsel2_mask: assert property (p_fsel2_mask) else $error("fsel2 reserved bit set"); // RULE_09

    property p_port_drive;
        (ce && !sel_any[4] && !s_q.odrn[4]) |=> port_pins_oe[4] == $past(s_q.drive[4])
                                             && port_pins_out[4] == $past(s_q.data[4]);
    endproperty
    a_port_drive: assert property (p_port_drive) else $error("port pin 4 wrong"); // RULE_07

    property p_tx0_route;
        (ce && s_q.fsel1[0] && !s_q.odrn[0])
            |=> port_pins_oe[0] && port_pins_out[0] == $past(serial0_transmit);
    endproperty
    a_tx0_route: assert property (p_tx0_route) else $error("tx0 not on pin 0"); // RULE_08

    property p_serial1_clear_to_send_route;
        (ce && s_q.fsel2[6] && s_q.inen[6])
            |=> serial1_clear_to_send == $past(s_q.level[6]);
    endproperty
    a_serial1_clear_to_send_route: assert property (p_serial1_clear_to_send_route) else $error("serial1_clear_to_send not from pin 6"); // RULE_09

    property p_open_drain;
        (ce && s_q.odrn[3]) |=> !port_pins_out[3];
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open-drain drove high"); // RULE_10

    property p_pull_follow;
        (w_go && address == `SBGP_OFF_PULL)
            |=> port_pins_pullup == $past(writedata[6:0]);
    endproperty
    a_pull_follow: assert property (p_pull_follow) else $error("pull-up not applied"); // RULE_11

    property p_input_block;
        (ce && !s_q.inen[1]) |=> !serial0_receive;
    endproperty
    a_input_block: assert property (p_input_block) else $error("input leaked"); // RULE_12

    property p_filter;
        (ce && s_q.sync2[5] != s_q.sync3[5]) |=> s_q.level[5] == $past(s_q.level[5]);
    endproperty
    a_filter: assert property (p_filter) else $error("unfiltered pin change"); // RULE_01

    c_write_read: cover property (w_go ##[1:4] r_go);
    c_alt_serial1_clock: cover property (s_q.fsel1[6] && serial1_clock_oe && port_pins_oe[6]);
    c_serial0_clear_to_send: cover property (serial0_clear_to_send);
    c_open_drain: cover property (s_q.odrn[2] && !port_pins_oe[2] && s_q.drive[2]);

endmodule

// File: dv/sbgp_pin_model.sv
// Purpose: pin side of the port, one wire per pin
// Assumes: the port's driver wins over the outside driver
// Notes:   an undriven pin without pull-up toggles each cycle
`timescale 1ns/10ps
`include "sbgp_params.svh"

module sbgp_pin_model (
    input  wire logic                   clock,
    input  wire logic [`SBGP_NPINS-1:0] pin_out,
    input  wire logic [`SBGP_NPINS-1:0] pin_oe,
    input  wire logic [`SBGP_NPINS-1:0] pin_pullup,
    input  wire logic [`SBGP_NPINS-1:0] ext_en,
    input  wire logic [`SBGP_NPINS-1:0] ext_val,
    output logic      [`SBGP_NPINS-1:0] pin_level
);
    logic [`SBGP_NPINS-1:0] float_q = 7'h00;

    // a floating pin must never read back a stale value
    always @(posedge clock) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < `SBGP_NPINS; i++) begin
            if (pin_oe[i])
                pin_level[i] = pin_out[i];
            else if (ext_en[i])
                pin_level[i] = ext_val[i];
            else if (pin_pullup[i])
                pin_level[i] = 1'b1;
            else
                pin_level[i] = float_q[i];
        end
    end
endmodule

// File: dv/test_seven_bit_gpio_port_mux.sv
// Purpose: self-checking bench of the seven-pin port
// Assumes: the slave answers after one wait cycle or more
// Notes:   ce is lowered once to show that it freezes pins and bus alike
`timescale 1ns/10ps
`include "sbgp_params.svh"

module test_seven_bit_gpio_port_mux;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic [5:0]  address = 6'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0]  byteenable = 4'hf;
    logic        ce = 1'b1;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [6:0]  pout, poe, ppull, pinen, lvl, per_out;
    logic [6:0]  ext_en = 7'h00;
    logic [6:0]  ext_val = 7'h00;
    logic [5:0]  per_in = 6'h00;
    int          fail_count = 0;
    int          compares = 0;
    logic [5:0]  offs [7] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h28, 6'h2c, 6'h38};
    logic [31:0] wval [7] = '{32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffbb,
                              32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff};
    // pin_value reads the pins: 0 and 4 carry the idle transmit lines, the rest pulled up
    logic [6:0]  rval [7] = '{7'h6e, 7'h7f, 7'h3b, 7'h44, 7'h7f, 7'h7f, 7'h7f};

    always #20 clock = ~clock;

    sbgp_port dut_u (.clock(clock), .srst(srst), .ce(ce), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .port_pins_in(lvl),
        .port_pins_out(pout), .port_pins_oe(poe), .port_pins_pullup(ppull),
        .port_pins_input_en(pinen), .serial0_transmit(per_in[0]),
        .serial0_clock_out(per_in[1]), .serial0_clock_oe(per_in[2]),
        .serial0_receive(per_out[0]), .serial0_clock_in(per_out[1]),
        .serial0_clear_to_send(per_out[2]), .serial1_transmit(per_in[3]),
        .serial1_clock_out(per_in[4]), .serial1_clock_oe(per_in[5]),
        .serial1_receive(per_out[4]), .serial1_clock_in(per_out[5]),
        .serial1_clear_to_send(per_out[6]), .remote_control_input(per_out[3]));

    sbgp_pin_model pins_u (.clock(clock), .pin_out(pout), .pin_oe(poe),
        .pin_pullup(ppull), .ext_en(ext_en), .ext_val(ext_val), .pin_level(lvl));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // one idle edge first, so a strobe is never set twice in one step
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= ~wr;
        write <= wr;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            give_verdict();
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hf, q);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, 4'hf, q);
        check(nm, q, exp);
    endtask

    task automatic t_reset_state();
        for (int i = 0; i < 7; i++)
            rd(offs[i], 32'h0000_0000, "reset word");
        check("pin drive", 32'(poe), 32'h0000_0000);
        check("pullup", 32'(ppull), 32'h0000_0000);
        check("input en", 32'(pinen), 32'h0000_0000);
        check("pin out", 32'(pout), 32'h0000_0000);
        check("periph in", 32'(per_out), 32'h0000_0000);
    endtask

    task automatic t_regs();
        logic [31:0] q;
        for (int i = 0; i < 7; i++)
            wr(offs[i], wval[i]);
        // let the pulled-up pins pass the input filter
        tick(8);
        for (int i = 0; i < 7; i++)
            rd(offs[i], 32'(rval[i]), "reg bits");
        for (int i = 0; i < 7; i++)
            wr(offs[i], 32'h0000_0000);
        bus(1'b1, offs[0], 32'h0000_007f, 4'h0, q);
        rd(offs[0], 32'h0000_0000, "no lane write");
        wr(6'h10, 32'hffff_ffff);
        rd(6'h10, 32'h0000_0000, "unmapped");
    endtask

    task automatic t_gpio();
        wr(offs[0], 32'h0000_0055);
        wr(offs[1], 32'h0000_007f);
        tick(2);
        check("gpio oe", 32'(poe), 32'h0000_007f);
        check("gpio out", 32'(pout), 32'h0000_0055);
        wr(offs[4], 32'h0000_007f);
        wr(offs[5], 32'h0000_007f);
        tick(2);
        check("pullup", 32'(ppull), 32'h0000_007f);
        check("od level", 32'(lvl), 32'h0000_0055);
        wr(offs[4], 32'h0000_0000);
        wr(offs[5], 32'h0000_0000);
        wr(offs[1], 32'h0000_0000);
    endtask

    task automatic t_input();
        ext_en <= 7'h7f;
        ext_val <= 7'h4c;
        wr(offs[0], 32'h0000_0033);
        tick(8);
        rd(offs[0], 32'h0000_0033, "latch read");
        wr(offs[6], 32'h0000_007f);
        tick(8);
        check("input en", 32'(pinen), 32'h0000_007f);
        rd(offs[0], 32'h0000_004c, "pin read");
    endtask

    task automatic t_alt();
        logic b;
        for (int k = 0; k < 2; k++) begin
            b = k[0];
            wr(offs[3], 32'h0000_0000);
            wr(offs[2], 32'h0000_007f);
            wr(offs[1], 32'h0000_0015);
            per_in <= {b, b, ~b, 1'b1, b, b};
            ext_en <= 7'h6a;
            ext_val <= {b, ~b, 1'b0, b, 1'b0, b, 1'b0};
            tick(8);
            check("alt oe", 32'(poe & 7'h55), 32'({b, 6'h15}));
            check("alt out", 32'(pout & 7'h55), 32'({b, 1'b0, ~b, 1'b0, b, 1'b0, b}));
            check("alt in", 32'(per_out & 7'h39), 32'({b, ~b, b, 2'b00, b}));
            wr(offs[2], 32'h0000_003b);
            wr(offs[1], 32'h0000_0011);
            wr(offs[3], 32'h0000_0044);
            ext_en <= 7'h44;
            ext_val <= {b, 3'b000, ~b, 2'b00};
            tick(8);
            check("cts", 32'(per_out & 7'h44), 32'({b, 3'b000, ~b, 2'b00}));
        end
    endtask

    // a low enable must hold the filter and stall the bus until it returns
    task automatic t_freeze();
        logic [31:0] q;
        ce <= 1'b0;
        ext_val <= 7'h04;
        tick(8);
        check("frozen cts", 32'(per_out & 7'h44), 32'h0000_0040);
        fork
            bus(1'b0, offs[3], 32'h0000_0000, 4'hf, q);
            begin
                tick(6);
                check("frozen wait", 32'(waitrequest), 32'h0000_0001);
                ce <= 1'b1;
            end
        join
        check("stalled read", q, 32'h0000_0044);
        tick(8);
        check("thawed cts", 32'(per_out & 7'h44), 32'h0000_0004);
    endtask

    initial begin
        tick(16);
        srst <= 1'b0;
        t_reset_state();
        t_regs();
        t_gpio();
        t_input();
        t_alt();
        t_freeze();
        srst <= 1'b1;
        tick(2);
        srst <= 1'b0;
        ext_en <= 7'h00;
        t_reset_state();
        give_verdict();
    end
endmodule
